// file: bench/tzc_chk.sv
// Checker: bus and pin-edge properties of the timer zero control block
`timescale 1ns/1ps
module tzc_chk (
   input wire logic        clock_in,               // Clock
   input wire logic        rst_b_in,               // Reset, active low
   input wire logic        ce_in,                  // Clock enable
   input wire logic        ext_irq_pin_in,         // Interrupt pin
   input wire logic        timer_ext_clock_pin_in, // Clock pin
   input wire logic        wb_cyc_i,               // Cycle
   input wire logic        wb_stb_i,               // Strobe
   input wire logic        wb_we_i,                // Write enable
   input wire logic [7:0]  wb_adr_i,               // Address
   input wire logic [3:0]  wb_sel_i,               // Selects
   input wire logic [31:0] wb_dat_i,               // Write data
   input wire logic [31:0] wb_dat_o,               // Read data
   input wire logic        wb_ack_o,               // Acknowledge
   input wire logic        irq_edge_pulse_out,     // Irq edge pulse
   input wire logic        timer_tick_out          // Count tick
);
   logic [7:0]  ctl_q;
   logic [15:0] ih_q;
   logic [15:0] ch_q;
   // Pin histories and a shadow of the control register
   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         ih_q  <= 16'h0000;
         ch_q  <= 16'h0000;
         ctl_q <= 8'h00;
      end else begin
         ih_q <= {ih_q[14:0], ext_irq_pin_in};
         ch_q <= {ch_q[14:0], timer_ext_clock_pin_in};
         if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == tzc_pkg::CTRL_ADDR)
            ctl_q <= wb_dat_i[7:0] & tzc_pkg::CTRL_WMASK;
      end
   end
   // Edges seen in the recent past
   wire ir = |(ih_q[14:0] & ~ih_q[15:1]);
   wire iff_ = |(~ih_q[14:0] & ih_q[15:1]);
   wire cr = |(ch_q[14:0] & ~ch_q[15:1]);
   wire cf = |(~ch_q[14:0] & ch_q[15:1]);
   wire mapped = wb_adr_i inside {tzc_pkg::CTRL_ADDR, tzc_pkg::COUNT_LO_ADDR,
                                  tzc_pkg::COUNT_HI_ADDR, tzc_pkg::STATUS_ADDR};
   default clocking @(posedge clock_in); endclocking
   default disable iff (!rst_b_in);
   chk_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_in |=> wb_ack_o)
      else $error("bus request not answered");
   chk_ack_drop: assert property (wb_ack_o && ce_in |=> !wb_ack_o)
      else $error("ack held over one cycle");
   chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data outside ack");
   chk_ctrl_read: assert property (wb_ack_o && !wb_we_i && wb_adr_i == tzc_pkg::CTRL_ADDR
      |-> wb_dat_o == {24'h0, ctl_q}) else $error("control readback wrong");
   chk_unmapped_zero: assert property (wb_ack_o && !wb_we_i && !mapped |-> wb_dat_o == 32'h0)
      else $error("unmapped read not zero");
   chk_irq_single: assert property (irq_edge_pulse_out && ce_in |=> !irq_edge_pulse_out)
      else $error("irq pulse too long");
   chk_irq_edge: assert property (irq_edge_pulse_out |-> (ctl_q[7] ? ir : iff_))
      else $error("irq pulse without selected edge");
   chk_ext_edge: assert property (timer_tick_out && !ctl_q[5] && !$past(ctl_q[5], 2)
      |-> (ctl_q[6] ? cr : cf)) else $error("tick without selected clock edge");
   cover property (wb_ack_o && wb_we_i);
   cover property (irq_edge_pulse_out && ctl_q[7]);
   cover property (timer_tick_out && !ctl_q[5]);
endmodule : tzc_chk

// file: bench/tzc_pin_model.sv
// Partner model: drives the interrupt pin and bursts on the external clock pin
`timescale 1ns/1ps
module tzc_pin_model (
   input  wire logic clock_in,    // Clock
   output logic      irq_pin_out, // Interrupt pin
   output logic      clk_pin_out  // External clock pin, rests low
);
   initial begin
      irq_pin_out = 1'b0;
      clk_pin_out = 1'b0;
   end
   // Set one pin and hold it long enough to pass the synchroniser
   task automatic set_pin(input logic clk, input logic v);
      if (clk) clk_pin_out <= v;
      else irq_pin_out <= v;
      repeat (12) @(posedge clock_in);
   endtask : set_pin
   // Burst of pulses with varying width, then the clock stands still
   task automatic burst(input int n);
      int w;
      repeat (n) begin
         w = 4 + $urandom_range(2);
         clk_pin_out <= 1'b1;
         repeat (w) @(posedge clock_in);
         clk_pin_out <= 1'b0;
         repeat (w) @(posedge clock_in);
      end
      repeat (8) @(posedge clock_in);
   endtask : burst
endmodule : tzc_pin_model

// file: bench/tzc_top_tb_top.sv
// Testbench: bus tasks, pin stimulus and read scoreboard for the timer zero control block
`timescale 1ns/1ps
module tzc_top_tb_top;
   localparam logic [7:0] c_adr = tzc_pkg::CTRL_ADDR;
   localparam logic [7:0] st_adr = tzc_pkg::STATUS_ADDR;
   localparam logic [7:0] lo_adr = tzc_pkg::COUNT_LO_ADDR;
   logic        clock_in = 1'b0, rst_b_in = 1'b0, ce_in = 1'b1;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
   logic        wb_ack_o, irq_edge_pulse_out, timer_tick_out, ext_irq_pin_in, timer_ext_clock_pin_in;
   logic [31:0] exp_q[$];
   int          err_total = 0, n_tests = 0;
   always #10 clock_in = ~clock_in;
   tzc_pin_model pm (.clock_in(clock_in), .irq_pin_out(ext_irq_pin_in), .clk_pin_out(timer_ext_clock_pin_in));
   tzc_top uut (.*);
   // One classic Wishbone cycle, held until ack is sampled
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
      @(posedge clock_in);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i, wb_sel_i} <= {2'b11, w, a, d, s};
      do @(posedge clock_in); while (wb_ack_o !== 1'b1);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s = 4'h1);
      bus(1'b1, a, {24'h0, d}, s);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      bus(1'b0, a, 32'h0, 4'hf);
   endtask : rd
   // Scoreboard: each read answer is compared with the oldest note
   always @(posedge clock_in) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0) begin
         n_tests++;
         if (exp_q.size() == 0 || wb_dat_o !== exp_q[0]) begin
            err_total++;
            $display("ERROR t=%0t got=%h exp=%h", $time, wb_dat_o, exp_q.size() ? exp_q[0] : 32'h0);
         end
         if (exp_q.size() != 0) void'(exp_q.pop_front());
      end
   end
   task automatic conclude();
      err_total += exp_q.size();
      $display("Comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : conclude
   // Watchdog against a hang
   initial begin
      #1500000;
      err_total++;
      conclude();
   end
   // Main sequence
   initial begin
      logic [7:0] v;
      int r;
      void'($urandom(99750));
      repeat (10) @(posedge clock_in);
      rst_b_in <= 1'b1;
      rd(c_adr, 32'h0);
      rd(8'h7c, 32'h0);
      // random values, low bit reads zero, write without sel0 ignored
      repeat (4) begin
         v = $urandom;
         wr(c_adr, v);
         wr(c_adr, ~v, 4'he);
         fork
            rd(c_adr, {24'h0, v & 8'hfe});
            begin ce_in <= 1'b0; repeat (3) @(posedge clock_in); ce_in <= 1'b1; end
         join
      end
      for (int e = 0; e < 2; e++) begin
         wr(c_adr, {e[0], 7'h0});
         wr(st_adr, 8'h03);
         pm.set_pin(1'b0, 1'b1);
         rd(st_adr, {31'h0, e[0]});
         pm.set_pin(1'b0, 1'b0);
         rd(st_adr, 32'h1);
      end
      for (int e = 0; e < 2; e++) begin
         wr(c_adr, {1'b0, e[0], 6'h0});
         wr(st_adr, 8'h03);
         wr(lo_adr, 8'h0);
         wr(tzc_pkg::COUNT_HI_ADDR, 8'h0);
         pm.set_pin(1'b1, 1'b1);
         rd(lo_adr, {31'h0, e[0]});
         rd(st_adr, {30'h0, e[0], 1'b0});
         pm.set_pin(1'b1, 1'b0);
         rd(lo_adr, 32'h1);
         rd(st_adr, 32'h2);
      end
      // every prescale ratio, two and a half periods of edges
      for (int p = 0; p < 10; p++) begin
         r = 1 << (p > 7 ? 8 : p);
         v = (p == 9) ? 8'h1e : {3'b0, p[3:0], 1'b0};
         wr(c_adr, v | 8'h40);
         wr(lo_adr, 8'h0);
         wr(tzc_pkg::COUNT_HI_ADDR, 8'h0);
         pm.burst(2 * r + r / 2);
         rd(lo_adr, 32'h2);
      end
      // internal source at 1:256 ignores clock pin edges
      wr(c_adr, 8'h70);
      wr(st_adr, 8'h03);
      wr(lo_adr, 8'h0);
      wr(tzc_pkg::COUNT_HI_ADDR, 8'h5a);
      pm.burst(40);
      rd(lo_adr, 32'h1);
      rd(tzc_pkg::COUNT_HI_ADDR, 32'h5a);
      rd(st_adr, 32'h0);
      repeat (4) @(posedge clock_in);
      conclude();
   end
endmodule : tzc_top_tb_top
bind tzc_top tzc_chk u_chk (.*);

// file: logic/tzc_sync.sv
// Three-flop pin synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps

module tzc_sync (
   input  wire logic clock_in,     // System clock
   input  wire logic rst_b_in,     // Sync reset, active low
   input  wire logic ce_in,        // Clock enable
   input  wire logic pin_in,       // Asynchronous pin
   output logic      level_out,    // Filtered level
   output logic      rise_out,     // One-cycle rising pulse
   output logic      fall_out      // One-cycle falling pulse
);

   logic [2:0] sr_q;
   logic [2:0] sr_d;
   logic       lvl_q;
   logic       lvl_d;
   logic       rise_q;
   logic       rise_d;
   logic       fall_q;
   logic       fall_d;

   // Next state: level changes only when second and third flops agree
   always_comb begin
      sr_d   = {sr_q[1:0], pin_in};
      lvl_d  = lvl_q;
      rise_d = 1'b0;
      fall_d = 1'b0;
      if (sr_q[1] == sr_q[2]) begin
         lvl_d  = sr_q[2];
         rise_d = sr_q[2] & ~lvl_q;
         fall_d = ~sr_q[2] & lvl_q;
      end
   end

   // Registers
   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         sr_q   <= 3'h0;
         lvl_q  <= 1'b0;
         rise_q <= 1'b0;
         fall_q <= 1'b0;
      end else if (ce_in) begin
         sr_q   <= sr_d;
         lvl_q  <= lvl_d;
         rise_q <= rise_d;
         fall_q <= fall_d;
      end
   end

   assign level_out = lvl_q;
   assign rise_out  = rise_q;
   assign fall_out  = fall_q;

endmodule : tzc_sync

// file: logic/tzc_top.sv
// Timer zero control register, edge selection, prescaler and 16-bit count
//
// Register access over Wishbone was left to the implementer.
`timescale 1ns/1ps

module tzc_top (
   input  wire logic        clock_in,              // Instruction cycle clock
   input  wire logic        rst_b_in,              // Sync reset, active low
   input  wire logic        ce_in,                 // Clock enable, freezes state
   input  wire logic        ext_irq_pin_in,        // External interrupt pin
   input  wire logic        timer_ext_clock_pin_in,// External timer clock pin
   input  wire logic        wb_cyc_i,              // Wishbone cycle
   input  wire logic        wb_stb_i,              // Wishbone strobe
   input  wire logic        wb_we_i,               // Wishbone write enable
   input  wire logic [7:0]  wb_adr_i,              // Wishbone byte address
   input  wire logic [3:0]  wb_sel_i,              // Wishbone byte selects
   input  wire logic [31:0] wb_dat_i,              // Wishbone write data
   output logic [31:0]      wb_dat_o,              // Wishbone read data
   output logic             wb_ack_o,              // Wishbone acknowledge
   output logic             irq_edge_pulse_out,    // Selected interrupt edge seen
   output logic             timer_tick_out         // Count advanced
);

   // ==========================================================
   // Pin synchronisers
   //
   // Both pins are asynchronous to the instruction cycle clock.
   // A pin level counts only once it has stood for two cycles,
   // so a selected edge shows as a one-cycle pulse about four
   // cycles after the pin moves; shorter glitches are dropped.
   tzc_pkg::tzc_pins_s rise;
   tzc_pkg::tzc_pins_s fall;
   tzc_pkg::tzc_pins_s lvl;

   tzc_sync u_sync_irq (
      .clock_in  (clock_in),
      .rst_b_in  (rst_b_in),
      .ce_in     (ce_in),
      .pin_in    (ext_irq_pin_in),
      .level_out (lvl.irq),
      .rise_out  (rise.irq),
      .fall_out  (fall.irq)
   );

   tzc_sync u_sync_clk (
      .clock_in  (clock_in),
      .rst_b_in  (rst_b_in),
      .ce_in     (ce_in),
      .pin_in    (timer_ext_clock_pin_in),
      .level_out (lvl.ext_clk),
      .rise_out  (rise.ext_clk),
      .fall_out  (fall.ext_clk)
   );

   // ==========================================================
   // State
   logic [7:0]          ctrl_q;
   logic [7:0]          ctrl_d;
   logic [15:0]         count_q;
   logic [15:0]         count_d;
   logic [7:0]          ps_q;
   logic [7:0]          ps_d;
   logic                irq_flag_q;
   logic                irq_flag_d;
   logic                ext_flag_q;
   logic                ext_flag_d;
   logic                irq_pulse_q;
   logic                irq_pulse_d;
   logic                tick_q;
   logic                tick_d;
   logic [31:0]         dat_q;
   logic [31:0]         dat_d;
   logic                ack_q;
   logic                ack_d;
   tzc_pkg::tzc_ctrl_s  cfg;
   logic                irq_edge;
   logic                ext_edge;
   logic                src_edge;
   logic [7:0]          ps_limit;
   logic                wr_stb;
   logic                rd_stb;
   logic                wr_ctrl;
   logic                wr_lo;
   logic                wr_hi;
   logic                wr_status;

   // Field decode
   // Fields come straight from the stored register, so a new
   // setting applies from the cycle after the write.
   assign cfg.irq_edge_select           = ctrl_q[tzc_pkg::IRQ_EDGE_BIT];
   assign cfg.ext_clock_edge_select     = ctrl_q[tzc_pkg::EXT_EDGE_BIT];
   assign cfg.timer_clock_source_select = ctrl_q[tzc_pkg::SRC_SEL_BIT];
   assign cfg.timer_prescale_select     = ctrl_q[tzc_pkg::PS_HI_BIT:tzc_pkg::PS_LO_BIT];

   assign irq_edge = cfg.irq_edge_select ? rise.irq : fall.irq;

   assign ext_edge = cfg.ext_clock_edge_select ? rise.ext_clk : fall.ext_clk;

   // source select; internal source qualifies every cycle
   // edge select unused on internal source
   assign src_edge = cfg.timer_clock_source_select ? 1'b1 : ext_edge;

   // Prescale codes 0 to 7 double the ratio each step; any code
   // with the top bit set gives the longest ratio, so the lower
   // three bits are ignored there.
   // prescale terminal count, ratio minus one
   always_comb begin
      if (cfg.timer_prescale_select[tzc_pkg::PS_TOP_BIT]) begin
         ps_limit = tzc_pkg::PS_LIMIT_TOP;
      end else begin
         ps_limit = 8'((9'h001 << cfg.timer_prescale_select[2:0]) - 9'h001);
      end
   end

   // ==========================================================
   // Bus decode
   //
   // A request is taken on the edge that sees cycle and strobe
   // high while no acknowledge is out. The acknowledge itself
   // blocks a second take of the same held request, so a master
   // that keeps strobe up for one more cycle writes only once.
   // Writes need byte lane 0, the only lane with register bits;
   // the upper lanes are accepted and dropped.

   // Take strobes, one per request
   assign wr_stb    = wb_cyc_i & wb_stb_i & ~ack_q & wb_we_i;
   assign rd_stb    = wb_cyc_i & wb_stb_i & ~ack_q & ~wb_we_i;

   // Register write selects
   assign wr_ctrl   = wr_stb & wb_sel_i[0] & (wb_adr_i == tzc_pkg::CTRL_ADDR);
   assign wr_lo     = wr_stb & wb_sel_i[0] & (wb_adr_i == tzc_pkg::COUNT_LO_ADDR);
   assign wr_hi     = wr_stb & wb_sel_i[0] & (wb_adr_i == tzc_pkg::COUNT_HI_ADDR);
   assign wr_status = wr_stb & wb_sel_i[0] & (wb_adr_i == tzc_pkg::STATUS_ADDR);

   // ==========================================================
   // Control register
   //
   // Only the writable bits are stored, so bit 0 can never hold
   // a one; the read path masks it once more all the same.

   always_comb begin
      ctrl_d = ctrl_q;
      if (wr_ctrl) begin
         ctrl_d = wb_dat_i[7:0] & tzc_pkg::CTRL_WMASK;
      end
   end

   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         ctrl_q <= tzc_pkg::CTRL_RESET;
      end else if (ce_in) begin
         ctrl_q <= ctrl_d;
      end
   end

   // ==========================================================
   // Prescaler and count
   //
   // The prescaler counts qualifying source edges up to the
   // terminal value; the edge that finds it there restarts it
   // and advances the count. The internal source qualifies every
   // enabled cycle, so the ratio then counts instruction cycles.
   // A count write restarts the prescaler as well, so the first
   // advance after a reload always takes a full ratio, and it
   // wins over an advance in the same cycle so that no carry
   // leaks into the byte that was not written. A ratio lowered
   // below the running prescaler ends the period on the next
   // qualifying edge instead of wrapping through zero.

   always_comb begin
      count_d = count_q;
      ps_d    = ps_q;
      tick_d  = 1'b0;
      if (wr_lo) begin
         count_d = {count_q[15:8], wb_dat_i[7:0]};
         ps_d    = tzc_pkg::PS_RESET;
      end else if (wr_hi) begin
         count_d = {wb_dat_i[7:0], count_q[7:0]};
         ps_d    = tzc_pkg::PS_RESET;
      end else if (src_edge) begin
         if (ps_q >= ps_limit) begin
            ps_d    = tzc_pkg::PS_RESET;
            count_d = count_q + 16'h0001;
            tick_d  = 1'b1;
         end else begin
            ps_d = ps_q + 8'h01;
         end
      end
   end

   // Count, prescaler and tick registers
   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         count_q <= tzc_pkg::COUNT_RESET;
         ps_q    <= tzc_pkg::PS_RESET;
         tick_q  <= 1'b0;
      end else if (ce_in) begin
         count_q <= count_d;
         ps_q    <= ps_d;
         tick_q  <= tick_d;
      end
   end

   // ==========================================================
   // Edge flags and interrupt edge pulse
   //
   // Writing a one to a status bit clears that flag. An edge in
   // the same cycle as the clear sets it again, so software never
   // loses an event to a late clear. The interrupt edge pulse
   // follows the qualified edge by one cycle.

   // Flag next state; set wins over clear
   always_comb begin
      irq_flag_d  = irq_flag_q;
      ext_flag_d  = ext_flag_q;
      irq_pulse_d = irq_edge;
      if (wr_status && wb_dat_i[tzc_pkg::ST_IRQ_FLAG_BIT]) begin
         irq_flag_d = 1'b0;
      end
      if (wr_status && wb_dat_i[tzc_pkg::ST_EXT_FLAG_BIT]) begin
         ext_flag_d = 1'b0;
      end
      if (irq_edge) begin
         irq_flag_d = 1'b1;
      end
      // edge flag only with external source
      if (ext_edge && !cfg.timer_clock_source_select) begin
         ext_flag_d = 1'b1;
      end
   end

   // Flag and pulse registers
   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         irq_flag_q  <= 1'b0;
         ext_flag_q  <= 1'b0;
         irq_pulse_q <= 1'b0;
      end else if (ce_in) begin
         irq_flag_q  <= irq_flag_d;
         ext_flag_q  <= ext_flag_d;
         irq_pulse_q <= irq_pulse_d;
      end
   end

   // ==========================================================
   // Register bus answer
   //
   // Every taken request is acknowledged one cycle later, mapped
   // or not, and the acknowledge drops in the next cycle even if
   // the strobe is still high. Read data is zero outside the
   // acknowledge cycle, so no stale value lingers on the bus.
   // Count bytes are not latched together: a low then high read
   // can tear across a carry, and software must allow for that.

   // Acknowledge and read mux; unmapped reads zero
   always_comb begin
      ack_d = wb_cyc_i & wb_stb_i & ~ack_q;
      dat_d = 32'h0000_0000;
      if (rd_stb) begin
         unique case (wb_adr_i)
            tzc_pkg::CTRL_ADDR:     dat_d = {24'h000000, ctrl_q & tzc_pkg::CTRL_WMASK};
            tzc_pkg::COUNT_LO_ADDR: dat_d = {24'h000000, count_q[7:0]};
            tzc_pkg::COUNT_HI_ADDR: dat_d = {24'h000000, count_q[15:8]};
            tzc_pkg::STATUS_ADDR:   dat_d = {30'h0, ext_flag_q, irq_flag_q};
            default:                dat_d = 32'h0000_0000;
         endcase
      end
   end

   // Bus registers
   always_ff @(posedge clock_in) begin
      if (!rst_b_in) begin
         dat_q <= 32'h0000_0000;
         ack_q <= 1'b0;
      end else if (ce_in) begin
         dat_q <= dat_d;
         ack_q <= ack_d;
      end
   end

   // ==========================================================
   // Outputs
   //
   // Each output comes straight from a flip-flop. While the clock
   // enable is low every one of them holds its value, the bus
   // acknowledge included.
   assign wb_dat_o           = dat_q;
   assign wb_ack_o           = ack_q;
   assign irq_edge_pulse_out = irq_pulse_q;
   assign timer_tick_out     = tick_q;

endmodule : tzc_top

// file: pkg/tzc_pkg.sv
// Package: register map, field layout, reset values and carrier structs for the timer zero control block
package tzc_pkg;

   // ==========================================================
   // Register map (byte addresses; control index times four)
   localparam logic [7:0] CTRL_INDEX      = 8'h05;
   localparam logic [7:0] CTRL_ADDR       = 8'h14;  // Index times four
   localparam logic [7:0] COUNT_LO_ADDR   = 8'h40;
   localparam logic [7:0] COUNT_HI_ADDR   = 8'h44;
   localparam logic [7:0] STATUS_ADDR     = 8'h48;

   // ==========================================================
   // Control register field positions
   localparam int IRQ_EDGE_BIT   = 7;
   localparam int EXT_EDGE_BIT   = 6;
   localparam int SRC_SEL_BIT    = 5;
   localparam int PS_HI_BIT      = 4;
   localparam int PS_LO_BIT      = 1;
   localparam int PS_TOP_BIT     = 3;              // Within the four-bit field
   localparam logic [7:0] CTRL_WMASK = 8'hfe;     // Bit 0 unimplemented
   localparam logic [7:0] CTRL_RESET = 8'h00;

   // Status register field positions
   localparam int ST_IRQ_FLAG_BIT = 0;
   localparam int ST_EXT_FLAG_BIT = 1;

   // ==========================================================
   // Prescaler
   localparam int          PS_WIDTH   = 8;
   localparam logic [3:0]  PS_MAX_CODE = 4'h8;   // Any code with top bit set
   localparam logic [7:0]  PS_RESET   = 8'h00;
   localparam logic [7:0]  PS_LIMIT_TOP = 8'hff; // Terminal count at the longest ratio
   localparam logic [15:0] COUNT_RESET = 16'h0000;

   // Decoded control fields
   typedef struct packed {
      logic       irq_edge_select;
      logic       ext_clock_edge_select;
      logic       timer_clock_source_select;
      logic [3:0] timer_prescale_select;
   } tzc_ctrl_s;

   // Pin sync carrier
   typedef struct packed {
      logic irq;
      logic ext_clk;
   } tzc_pins_s;

endpackage : tzc_pkg
